/* hdl/timer_three_pkg.sv */
// Behaviour
// - with stop_on_receive set, the timer halts at once when the receiver has taken its first 4 bits.
// - stop_on_receive is ignored while start_mode selects either oscillator trimming mode.
// - start_mode 00 never starts the timer; 01 starts it when a transmission ends.
// - start_mode 10 trims the oscillator without underflow, start and stop on a rising edge.
// - start_mode 11 trims the oscillator with underflow allowed, start and stop on a rising edge.
// - with auto_restart set, the counter reloads from reload_value after reaching zero and goes on, except in start_mode 10 where it holds at zero.
// - with auto_restart clear, the counter counts down to zero and stops until a new start, except in start_mode 10 where it holds at zero and keeps running.
// - every underflow sets the timer interrupt flag.
// - clock_select 00 counts at the carrier rate and 01 at the carrier rate divided by 64.
// - clock_select 10 counts on timer zero underflows and 11 on timer one underflows.
// - each start loads the counter with the 16-bit value of both reload bytes.
// - reload writes do not disturb a running count and only act at the next start or the next auto_restart reload.
// - the live count reads as two read-only bytes, high byte holding bits 15 to 8.
// - the low byte of the preceding timer's count reads at offset 1Dh.
package timer_three_pkg;
    localparam logic [7:0] OFS_PREV_COUNT_LO = 8'h1D;
    localparam logic [7:0] OFS_CONTROL = 8'h1E;
    localparam logic [7:0] OFS_RELOAD_HI = 8'h1F;
    localparam logic [7:0] OFS_RELOAD_LO = 8'h20;
    localparam logic [7:0] OFS_COUNT_HI = 8'h21;
    localparam logic [7:0] OFS_COUNT_LO = 8'h22;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h29;
    localparam logic [7:0] CONTROL_WMASK = 8'hBB;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam int BIT_STOP_RX = 7;
    localparam int BIT_AUTO_RESTART = 3;
    localparam int RX_STOP_BITS = 4;
    localparam int CARRIER_KHZ = 13560;
    localparam int SLOW_HZ = 211875;  // slow tick rate in Hz
    localparam int SLOW_DIV = (CARRIER_KHZ * 1000) / SLOW_HZ;
    localparam int IRQ_BITS = 2;

    typedef enum logic [1:0] {
        START_NONE = 2'b00,
        START_TX_END = 2'b01,
        START_TRIM = 2'b10,
        START_TRIM_UF = 2'b11
    } start_mode_e;

    typedef enum logic [1:0] {
        CLK_CARRIER = 2'b00,
        CLK_SLOW = 2'b01,
        CLK_TIMER0 = 2'b10,
        CLK_TIMER1 = 2'b11
    } clock_select_e;

    typedef struct packed {
        logic stop_on_receive;
        logic reserved6;
        start_mode_e start_mode;
        logic auto_restart;
        logic reserved2;
        clock_select_e clock_select;
    } control_s;

    typedef struct packed {
        logic tx_end;
        logic rx_bit;
        logic trim_edge;
        logic carrier_tick;
        logic timer0_underflow;
        logic timer1_underflow;
    } events_s;
endpackage

/* hdl/timer_three.sv */
`timescale 1ns/1ps
module timer_three (
    input wire logic hclk,                         // bus clock
    input wire logic hresetn,                      // async reset, low
    input wire logic hsel,                         // slave select
    input wire logic [31:0] haddr,                 // byte address
    input wire logic [1:0] htrans,                 // transfer type
    input wire logic hwrite,                       // write flag
    input wire logic [2:0] hsize,                  // transfer size
    input wire logic [31:0] hwdata,                // write data
    input wire logic hready,                       // bus ready in
    output logic [31:0] hrdata,                    // read data
    output logic hreadyout,                        // slave ready
    output logic hresp,                            // always okay
    input wire timer_three_pkg::events_s ev,       // same-clock events
    input wire logic [7:0] prev_timer_count_low,   // preceding timer low byte
    output logic underflow,                        // underflow pulse
    output logic running,                          // counter running
    output logic irq                               // level interrupt
);
    import timer_three_pkg::*;

    logic ctl_wr_q;
    logic [7:0] wr_addr_q;
    control_s ctrl_q;
    logic [7:0] reload_hi_q;
    logic [7:0] reload_lo_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic run_q;
    logic run_d;
    logic [2:0] rx_cnt_q;
    logic [IRQ_BITS-1:0] status_q;
    logic [IRQ_BITS-1:0] mask_q;
    logic [5:0] div_q;
    logic slow_tick_q;
    logic underflow_q;
    logic irq_q;
    logic [31:0] hrdata_q;

    // address phase capture
    wire addr_ok = hsel && hready && htrans[1];
    wire [7:0] idx = haddr[9:2];
    logic [7:0] rd_val;

    function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
        sel = (a == o);
    endfunction

    // write data phase strobes
    wire wr_ctl = ctl_wr_q && sel(wr_addr_q, OFS_CONTROL);
    wire wr_rhi = ctl_wr_q && sel(wr_addr_q, OFS_RELOAD_HI);
    wire wr_rlo = ctl_wr_q && sel(wr_addr_q, OFS_RELOAD_LO);
    wire wr_sts = ctl_wr_q && sel(wr_addr_q, OFS_IRQ_STATUS);
    wire wr_msk = ctl_wr_q && sel(wr_addr_q, OFS_IRQ_MASK);

    wire trim_mode = ctrl_q.start_mode[1];
    // tick source
    wire tick = (ctrl_q.clock_select == CLK_CARRIER) ? ev.carrier_tick :
                (ctrl_q.clock_select == CLK_SLOW) ? slow_tick_q :
                (ctrl_q.clock_select == CLK_TIMER0) ? ev.timer0_underflow :
                ev.timer1_underflow;
    wire start_tx = (ctrl_q.start_mode == START_TX_END) && ev.tx_end;
    wire trim_toggle = trim_mode && ev.trim_edge;
    wire rx_stop = ctrl_q.stop_on_receive && !trim_mode && run_q && ev.rx_bit &&
                   (rx_cnt_q == 3'(RX_STOP_BITS - 1));
    // trimming without underflow holds at zero
    wire uf_block = (ctrl_q.start_mode == START_TRIM);
    wire uf_now = run_q && tick && (count_q == 16'h0000) && !uf_block;
    wire [15:0] reload_value = {reload_hi_q, reload_lo_q};

    always_comb begin
        count_d = count_q;
        run_d = run_q;
        if (start_tx || (trim_toggle && !run_q)) begin
            count_d = reload_value;
            run_d = 1'b1;
        end else if (trim_toggle || rx_stop) begin
            run_d = 1'b0;
        end else if (run_q && tick) begin
            if (count_q != 16'h0000) begin
                count_d = count_q - 16'h0001;
            end else if (uf_now && ctrl_q.auto_restart) begin
                count_d = reload_value;
            end else if (uf_now) begin
                run_d = 1'b0;
            end
        end
    end

    always_comb begin
        case (idx)
            OFS_PREV_COUNT_LO: rd_val = prev_timer_count_low;
            OFS_CONTROL: rd_val = ctrl_q & CONTROL_WMASK;
            OFS_RELOAD_HI: rd_val = reload_hi_q;
            OFS_RELOAD_LO: rd_val = reload_lo_q;
            OFS_COUNT_HI: rd_val = count_q[15:8];
            OFS_COUNT_LO: rd_val = count_q[7:0];
            OFS_IRQ_STATUS: rd_val = {6'h00, status_q};
            OFS_IRQ_MASK: rd_val = {6'h00, mask_q};
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_wr_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            ctl_wr_q <= addr_ok && hwrite;
            wr_addr_q <= idx;
            if (addr_ok && !hwrite) begin
                hrdata_q <= {24'h000000, rd_val};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= control_s'(CONTROL_RESET);
            reload_hi_q <= RELOAD_RESET[15:8];
            reload_lo_q <= RELOAD_RESET[7:0];
            mask_q <= '0;
        end else begin
            if (wr_ctl) ctrl_q <= control_s'(hwdata[7:0] & CONTROL_WMASK);
            if (wr_rhi) reload_hi_q <= hwdata[7:0];
            if (wr_rlo) reload_lo_q <= hwdata[7:0];
            if (wr_msk) mask_q <= hwdata[IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= RELOAD_RESET;
            run_q <= 1'b0;
            underflow_q <= 1'b0;
            rx_cnt_q <= 3'h0;
        end else begin
            count_q <= count_d;
            run_q <= run_d;
            underflow_q <= uf_now;
            // count received bits only while running
            if (!run_q || start_tx) rx_cnt_q <= 3'h0;
            else if (ev.rx_bit && rx_cnt_q != 3'(RX_STOP_BITS)) rx_cnt_q <= rx_cnt_q + 3'h1;
        end
    end

    // slow tick divides carrier ticks by SLOW_DIV
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 6'h00;
            slow_tick_q <= 1'b0;
        end else begin
            slow_tick_q <= ev.carrier_tick && (div_q == 6'(SLOW_DIV - 1));
            if (ev.carrier_tick) div_q <= (div_q == 6'(SLOW_DIV - 1)) ? 6'h00 : div_q + 6'h01;
        end
    end

    // bit0 underflow, bit1 receive stop; set beats clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= '0;
            irq_q <= 1'b0;
        end else begin
            status_q <= (status_q & ~({IRQ_BITS{wr_sts}} & hwdata[IRQ_BITS-1:0]))
                        | {rx_stop, uf_now};
            irq_q <= |(status_q & mask_q);
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign underflow = underflow_q;
    assign running = run_q;
    assign irq = irq_q;
endmodule

/* tb/timer_three_chk.sv */
`timescale 1ns/1ps
module timer_three_chk (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // type
    input wire logic hwrite, // write
    input wire logic hready, // ready
    input wire logic [31:0] hrdata, // rdata
    input wire logic hreadyout, // ready
    input wire logic hresp, // resp
    input wire timer_three_pkg::events_s ev, // events
    input wire logic [7:0] prev_timer_count_low, // byte
    input wire logic underflow, // pulse
    input wire logic running // state
);
    import timer_three_pkg::*;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire rd = hsel && hready && htrans[1] && !hwrite;
    wire tick = ev.carrier_tick || ev.timer0_underflow || ev.timer1_underflow;
    resp_okay_a: assert property (hresp == 1'b0) else $error("bad response");
    zero_wait_a: assert property (hreadyout) else $error("wait state");
    prev_read_a: assert property (rd && haddr == {22'h0, OFS_PREV_COUNT_LO, 2'h0}
        |=> hrdata == {24'h0, $past(prev_timer_count_low)}) else $error("prev byte");
    reserved_zero_a: assert property (rd && haddr == {22'h0, OFS_CONTROL, 2'h0}
        |=> !hrdata[6] && !hrdata[2]) else $error("reserved bits");
    unmapped_zero_a: assert property (rd && haddr == 32'h0 |=> hrdata == 32'h0)
        else $error("unmapped read");
    // the slow tick is a registered carrier tick, so its cause lies one cycle further back
    uf_tick_a: assert property (underflow |-> $past(tick) || $past(ev.carrier_tick, 2))
        else $error("tickless");
    uf_running_a: assert property (underflow |-> $past(running))
        else $error("underflow while stopped");
    start_cause_a: assert property (!running && !ev.tx_end && !ev.trim_edge
        |=> !running) else $error("start without event");
endmodule

bind timer_three timer_three_chk i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .ev, .prev_timer_count_low, .underflow, .running);

/* tb/reload_countdown_timer_three_bench.sv */
`timescale 1ns/1ps
module reload_countdown_timer_three_bench;
    import timer_three_pkg::*;
    localparam logic [5:0] TX = 6'h20, RX = 6'h10, TRIM = 6'h08, TICK = 6'h04;
    localparam logic [5:0] U0 = 6'h02, U1 = 6'h01;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, underflow, running, irq, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [7:0] q;
    logic [7:0] prev_timer_count_low = 8'hA5;
    events_s ev = '0;
    int mismatches = 0, total_checks = 0, cyc = 0, ufs = 0, u0 = 0;
    timer_three i_timer_three (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ev,
        .prev_timer_count_low, .underflow, .running, .irq);
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (underflow) ufs++;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up;
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single word transfer; read data taken at the data phase edge
    task acc(input logic w, input logic [7:0] o, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, o, 2'h0};
        do @(posedge hclk); while (!hreadyout);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (!hreadyout);
        q = hrdata[7:0];
    endtask
    task rd(input logic [7:0] o, input logic [7:0] exp);
        acc(0, o, 8'h0);
        chk(q, exp);
    endtask
    task pulse(input logic [5:0] e);
        @(posedge hclk);
        ev <= e;
        @(posedge hclk);
        ev <= '0;
        #1;
    endtask
    task run_is(input logic e);
        chk({7'h0, running}, {7'h0, e});
    endtask
    task t_regs;
        rd(OFS_CONTROL, 8'h00);
        acc(1, OFS_CONTROL, 8'hFF);
        rd(OFS_CONTROL, 8'hBB);
        acc(1, OFS_COUNT_HI, 8'h55);
        rd(OFS_COUNT_HI, 8'h00);
        rd(OFS_PREV_COUNT_LO, 8'hA5);
        prev_timer_count_low <= 8'h5A;
        rd(OFS_PREV_COUNT_LO, 8'h5A);
        rd(8'h00, 8'h00);
        $display("registers done");
    endtask
    task t_oneshot;
        acc(1, OFS_CONTROL, 8'h00);
        pulse(TX);
        run_is(0);
        acc(1, OFS_RELOAD_LO, 8'h03);
        acc(1, OFS_IRQ_MASK, 8'h01);
        acc(1, OFS_CONTROL, 8'h10);
        pulse(TX);
        run_is(1);
        rd(OFS_COUNT_LO, 8'h03);
        u0 = ufs;
        repeat (3) pulse(TICK);
        rd(OFS_COUNT_LO, 8'h00);
        pulse(TICK);
        rd(OFS_IRQ_STATUS, 8'h01);
        run_is(0);
        chk(8'(ufs - u0), 8'h01);
        chk({7'h0, irq}, 8'h01);
        acc(1, OFS_IRQ_MASK, 8'h00);
        // irq is registered behind the mask, one cycle late
        @(posedge hclk);
        #1;
        chk({7'h0, irq}, 8'h00);
        acc(1, OFS_IRQ_MASK, 8'h01);
        acc(1, OFS_IRQ_STATUS, 8'h01);
        rd(OFS_IRQ_STATUS, 8'h00);
        chk({7'h0, irq}, 8'h00);
        $display("one shot done");
    endtask
    task t_restart;
        acc(1, OFS_RELOAD_LO, 8'h02);
        acc(1, OFS_CONTROL, 8'h18);
        pulse(TX);
        acc(1, OFS_RELOAD_LO, 8'h09);
        rd(OFS_COUNT_LO, 8'h02);
        repeat (4) pulse(RX);
        run_is(1);
        u0 = ufs;
        repeat (3) pulse(TICK);
        rd(OFS_IRQ_STATUS, 8'h01);
        run_is(1);
        chk(8'(ufs - u0), 8'h01);
        $display("restart done");
    endtask
    task t_rxstop;
        acc(1, OFS_CONTROL, 8'h90);
        pulse(TX);
        repeat (3) pulse(RX);
        run_is(1);
        pulse(RX);
        run_is(0);
        acc(1, OFS_RELOAD_LO, 8'h01);
        acc(1, OFS_CONTROL, 8'hA0);
        pulse(TRIM);
        rd(OFS_COUNT_LO, 8'h01);
        repeat (4) pulse(RX);
        u0 = ufs;
        repeat (3) pulse(TICK);
        run_is(1);
        rd(OFS_COUNT_LO, 8'h00);
        pulse(TRIM);
        run_is(0);
        acc(1, OFS_CONTROL, 8'hB0);
        pulse(TRIM);
        repeat (4) pulse(RX);
        repeat (2) pulse(TICK);
        rd(OFS_COUNT_HI, 8'h00);
        chk(8'(ufs - u0), 8'h01);
        $display("receive stop and trim done");
    endtask
    task t_clksel;
        acc(1, OFS_RELOAD_HI, 8'h01);
        acc(1, OFS_RELOAD_LO, 8'h00);
        acc(1, OFS_CONTROL, 8'h10);
        pulse(TX);
        pulse(TICK);
        rd(OFS_COUNT_HI, 8'h00);
        rd(OFS_COUNT_LO, 8'hFF);
        acc(1, OFS_RELOAD_HI, 8'h00);
        acc(1, OFS_RELOAD_LO, 8'h02);
        for (int k = 1; k < 4; k++) begin
            acc(1, OFS_CONTROL, 8'h10 | 8'(k));
            pulse(TX);
            pulse(k == 1 ? U0 | U1 : k == 2 ? TICK | U1 : TICK | U0);
            rd(OFS_COUNT_LO, 8'h02);
            if (k == 1) repeat (SLOW_DIV) pulse(TICK);
            else pulse(k == 2 ? U0 : U1);
            rd(OFS_COUNT_LO, 8'h01);
        end
        $display("clock select done");
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1;
        t_regs;
        t_oneshot;
        t_restart;
        t_rxstop;
        t_clksel;
        wrap_up;
    end
endmodule
